//--- logic/pss_pkg.sv
/*
  package of the power supervision sequencer: switch codes, timing figures
  and derived cycle counts.
  assumes a 20 mhz controller clock and a one-tick-per-millisecond divider.
*/
package pss_pkg;
  // ==========================================================================
  // clock and tick
  // ==========================================================================
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // ==========================================================================
  // input configuration switch codes
  // ==========================================================================
  localparam logic [3:0] CFG_TEST = 4'h0;
  localparam logic [3:0] CFG_PULLDOWN = 4'h1;
  localparam logic [3:0] CFG_PULLUP = 4'h2;
  // ==========================================================================
  // timing select switch codes
  // ==========================================================================
  localparam logic [3:0] SEL_BYPASS = 4'h0;
  localparam logic [3:0] SEL_USER = 4'ha;
  // ==========================================================================
  // times in milliseconds, as printed
  // ==========================================================================
  localparam int unsigned T_0S_MS = 0;
  localparam int unsigned T_1S_MS = 1000;
  localparam int unsigned T_2S_MS = 2000;
  localparam int unsigned T_5S_MS = 5000;
  localparam int unsigned T_60S_MS = 60000;
  localparam int unsigned T_120S_MS = 120000;
  localparam int unsigned T_300S_MS = 300000;
  localparam int unsigned T_PULSE_MS = 250;
  localparam int unsigned T_LONG_MS = 5000;
  // counter width in bits
  localparam int unsigned MS_W = 20;
  // reset values
  localparam logic [1:0] RST_PWR = 2'b00;
endpackage : pss_pkg

//--- logic/pss_sequencer.sv
/*
  power supervision sequencer: power fail monitor and remote on/off
  sequencer with debouncing, start-up hold, hard-off timeout, pulse modes.
  assumes the control pin, supply-present pin and processor signals are
  asynchronous; switches are quasi-static; reset is synchronous, active high.
*/
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - input configuration switch selects pin behaviour
// - timing switch zero is bypass power-fail
// - power fail pin monitored, exposed as flag
// - active control requests shutdown, then power off
// - modes six to nine use pulse commands
// - modes six, eight start up on pulse
// - modes eight, nine: long pulse forces off
// - control input debounced per switch position
// - request held for start-up time while booting
// - after request, hard-off timeout cuts power
// - position a user timings, b-f reserved
// - leds follow stop, board ready, setup bits
// - power fail flag reads low on failure
module pss_sequencer #(
  parameter int unsigned TICK_CYCLES_P = pss_pkg::TICK_CYCLES, // cycles per tick
  parameter int unsigned USER_DEB_ON_P = pss_pkg::T_2S_MS, // user on debounce, ms
  parameter int unsigned USER_DEB_OFF_P = pss_pkg::T_60S_MS, // user off debounce, ms
  parameter int unsigned USER_START_P = pss_pkg::T_60S_MS, // user start-up hold, ms
  parameter int unsigned USER_HARD_P = pss_pkg::T_60S_MS // user hard-off, ms
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [3:0] input_config_switch_i, // pin configuration
  input wire logic [3:0] timing_select_switch_i, // mode / timing select
  input wire logic ctrl_pin_i, // power fail or remote on/off pin
  input wire logic supply_ok_i, // supply power present
  input wire logic booted_i, // processor finished booting
  input wire logic stop_bit_i, // control register stop bit
  input wire logic board_ready_bit_i, // setup register board ready bit
  input wire logic aux_bit_i, // setup register aux bit
  output logic supply_loss_flag_n_o, // status flag, low on power fail
  output logic pulldown_en_o, // pin pulldown enable
  output logic pullup_en_o, // pin pullup enable
  output logic shutdown_req_o, // request to processor: go to shutdown
  output logic main_power_on_o, // main supply switch
  output logic led_red_o, // front red led
  output logic led_green_o, // front green led
  output logic led_aux_o // optional aux led
);
  import pss_pkg::*;

  // refuse a zero tick and user timings that the interval counters cannot hold
  if ((TICK_CYCLES_P < 1) || ((USER_DEB_ON_P >> MS_W) != 0) || ((USER_DEB_OFF_P >> MS_W) != 0)
      || ((USER_START_P >> MS_W) != 0) || ((USER_HARD_P >> MS_W) != 0)) begin : g_bad_param
    $error("tick or user timing outside what the counters can serve");
  end

  // ==========================================================================
  // types and declarations
  // ==========================================================================
  typedef enum logic [2:0] {
    PSS_OFF, PSS_RUN, PSS_HOLD, PSS_SHUTDOWN, PSS_PULSE
  } pss_state_type;

  typedef struct packed {
    logic [MS_W-1:0] deb_on;
    logic [MS_W-1:0] deb_off;
    logic [MS_W-1:0] start;
    logic [MS_W-1:0] hard;
  } pss_timing_type;

  pss_state_type state_reg; // sequencer state
  logic [1:0] ctrl_sync_reg; // pin synchroniser
  logic [1:0] sup_sync_reg; // supply-present synchroniser
  logic [1:0] boot_sync_reg; // boot-done synchroniser
  logic [31:0] div_reg; // tick divider
  logic tick_reg; // one-cycle millisecond pulse
  logic deb_reg; // debounced control level
  logic deb_prev_reg; // previous debounced level
  logic [MS_W-1:0] deb_cnt_reg; // debounce interval count
  logic [MS_W-1:0] seq_cnt_reg; // hold / hard-off count
  logic [MS_W-1:0] pulse_cnt_reg; // pulse width count
  logic ctrl_raw; // synchronised pin, active high
  logic sup_ok; // synchronised supply present
  logic booted; // synchronised boot done
  logic remote_mode; // remote on/off modes active
  logic pulse_mode; // modes six to nine
  logic start_mode; // modes six and eight
  logic long_mode; // modes eight and nine
  logic rise; // debounced rising edge
  logic fall; // debounced falling edge
  logic long_hit; // pulse exceeded the long limit
  pss_timing_type tm; // timing of current position
  // one tick step at full counter width
  localparam logic [MS_W-1:0] CNT_STEP = {{(MS_W-1){1'b0}}, 1'b1};

  // ==========================================================================
  // timing table
  // ==========================================================================
  function automatic logic [MS_W-1:0] ms(input int unsigned v);
    ms = v[MS_W-1:0];
  endfunction

  // timing lookup per switch position
  // debounce per position
  function automatic pss_timing_type timing_of(input logic [3:0] pos);
    pss_timing_type t;
    t = '{ms(T_0S_MS), ms(T_0S_MS), ms(T_60S_MS), ms(T_60S_MS)};
    unique case (pos)
      4'h1: t = '{ms(T_2S_MS), ms(T_60S_MS), ms(T_5S_MS), ms(T_60S_MS)};
      4'h2: t = '{ms(T_2S_MS), ms(T_60S_MS), ms(T_60S_MS), ms(T_300S_MS)};
      4'h3: t = '{ms(T_2S_MS), ms(T_60S_MS), ms(T_60S_MS), ms(T_120S_MS)};
      4'h4: t = '{ms(T_1S_MS), ms(T_5S_MS), ms(T_5S_MS), ms(T_60S_MS)};
      4'h5: t = '{ms(T_5S_MS), ms(T_5S_MS), ms(T_60S_MS), ms(T_60S_MS)};
      4'h9: t = '{ms(T_0S_MS), ms(T_0S_MS), ms(T_60S_MS), ms(T_0S_MS)};
      4'ha: t = '{ms(USER_DEB_ON_P), ms(USER_DEB_OFF_P), ms(USER_START_P),
                  ms(USER_HARD_P)};
      default: t = '{ms(T_0S_MS), ms(T_0S_MS), ms(T_60S_MS), ms(T_60S_MS)};
    endcase
    timing_of = t;
  endfunction

  // ==========================================================================
  // mode decode
  // ==========================================================================
  // position zero is bypass
  always_comb begin
    tm = timing_of(timing_select_switch_i);
    remote_mode = (input_config_switch_i == CFG_PULLDOWN) &&
                  (timing_select_switch_i != SEL_BYPASS) &&
                  (timing_select_switch_i <= SEL_USER);
    pulse_mode = (timing_select_switch_i >= 4'h6) && (timing_select_switch_i <= 4'h9);
    start_mode = (timing_select_switch_i == 4'h6) || (timing_select_switch_i == 4'h8);
    long_mode = (timing_select_switch_i == 4'h8) || (timing_select_switch_i == 4'h9);
    rise = deb_reg && !deb_prev_reg;
    fall = !deb_reg && deb_prev_reg;
    long_hit = long_mode && deb_reg && (pulse_cnt_reg >= ms(T_LONG_MS));
  end

  // ==========================================================================
  // synchronisers
  // ==========================================================================
  // two flip-flops on every asynchronous input
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_sync_reg <= 2'b00;
      sup_sync_reg <= 2'b00;
      boot_sync_reg <= 2'b00;
    end else begin
      ctrl_sync_reg <= {ctrl_sync_reg[0], ctrl_pin_i};
      sup_sync_reg <= {sup_sync_reg[0], supply_ok_i};
      boot_sync_reg <= {boot_sync_reg[0], booted_i};
    end
  end
  assign ctrl_raw = ctrl_sync_reg[1];
  assign sup_ok = sup_sync_reg[1];
  assign booted = boot_sync_reg[1];

  // ==========================================================================
  // millisecond tick
  // ==========================================================================
  // fixed tick from clock
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_reg <= 32'h0;
      tick_reg <= 1'b0;
    end else if (div_reg >= TICK_CYCLES_P - 1) begin
      div_reg <= 32'h0;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h1;
      tick_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // debouncer
  // ==========================================================================
  // stable for on/off time
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      deb_reg <= 1'b0;
      deb_cnt_reg <= '0;
    end else if (ctrl_raw == deb_reg) begin
      // input agrees with output: interval restarts
      deb_cnt_reg <= '0;
    end else if (deb_cnt_reg >= (ctrl_raw ? tm.deb_on : tm.deb_off)) begin
      deb_reg <= ctrl_raw;
      deb_cnt_reg <= '0;
    end else if (tick_reg) begin
      deb_cnt_reg <= deb_cnt_reg + CNT_STEP;
    end
  end

  // previous debounced level and pulse width
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      deb_prev_reg <= 1'b0;
      pulse_cnt_reg <= '0;
    end else begin
      deb_prev_reg <= deb_reg;
      if (!deb_reg) begin
        pulse_cnt_reg <= '0;
      end else if (tick_reg && (pulse_cnt_reg != '1)) begin
        pulse_cnt_reg <= pulse_cnt_reg + CNT_STEP;
      end
    end
  end

  // ==========================================================================
  // sequencer
  // ==========================================================================
  // state and interval counter
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= PSS_RUN;
      seq_cnt_reg <= '0;
    end else if (!remote_mode) begin
      // bypass, reserved positions, power fail or test: power stays on
      state_reg <= PSS_RUN;
      seq_cnt_reg <= '0;
    end else if (long_hit && (state_reg != PSS_OFF)) begin
      state_reg <= PSS_OFF;
      seq_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        PSS_OFF: begin
          seq_cnt_reg <= '0;
          // pulse starts system
          // a pulse restarts; the release of a long hard-off press does not
          if (start_mode && sup_ok && fall &&
              !(long_mode && (pulse_cnt_reg >= ms(T_LONG_MS)))) begin
            state_reg <= PSS_RUN;
          end else if (!pulse_mode && !deb_reg && sup_ok) begin
            // level modes come back on when control is released
            state_reg <= PSS_RUN;
          end
        end
        PSS_RUN: begin
          seq_cnt_reg <= '0;
          // pulse modes act on a pulse
          // level modes act on active level
          if (pulse_mode ? rise : deb_reg) begin
            state_reg <= booted ? PSS_SHUTDOWN : PSS_HOLD;
          end
        end
        PSS_HOLD: begin
          if (booted || (seq_cnt_reg >= tm.start)) begin
            state_reg <= PSS_SHUTDOWN;
            seq_cnt_reg <= '0;
          end else if (tick_reg) begin
            seq_cnt_reg <= seq_cnt_reg + CNT_STEP;
          end
        end
        PSS_SHUTDOWN: begin
          if (seq_cnt_reg >= tm.hard) begin
            state_reg <= PSS_PULSE;
            seq_cnt_reg <= '0;
          end else if (tick_reg) begin
            seq_cnt_reg <= seq_cnt_reg + CNT_STEP;
          end
        end
        PSS_PULSE: begin
          // wait for the command to be released before re-arming
          seq_cnt_reg <= '0;
          if (!deb_reg) begin
            state_reg <= PSS_OFF;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  // registered outputs
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      supply_loss_flag_n_o <= 1'b1;
      pulldown_en_o <= 1'b0;
      pullup_en_o <= 1'b0;
      shutdown_req_o <= 1'b0;
      main_power_on_o <= 1'b1;
      led_red_o <= 1'b0;
      led_green_o <= 1'b0;
      led_aux_o <= 1'b0;
    end else begin
      pulldown_en_o <= (input_config_switch_i == CFG_PULLDOWN);
      pullup_en_o <= (input_config_switch_i == CFG_PULLUP);
      if (input_config_switch_i == CFG_TEST) begin
        supply_loss_flag_n_o <= 1'b0;
      end else if (input_config_switch_i == CFG_PULLUP) begin
        supply_loss_flag_n_o <= ctrl_raw;
      end else begin
        supply_loss_flag_n_o <= 1'b1;
      end
      shutdown_req_o <= (state_reg == PSS_SHUTDOWN);
      main_power_on_o <= (state_reg != PSS_OFF) && (state_reg != PSS_PULSE);
      led_red_o <= stop_bit_i;
      led_green_o <= board_ready_bit_i;
      led_aux_o <= aux_bit_i;
    end
  end

endmodule // pss_sequencer

`default_nettype wire

//--- verif/pss_ctrl_source.sv
/*
  model of the external switch driving the control pin.
  assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module pss_ctrl_source (
  input wire logic clk_i,
  input wire logic pullup_en_i,
  input wire logic pulldown_en_i,
  output logic ctrl_pin_o
);
  logic drv_en = 1'b0; // switch actively drives the line
  logic drv_val = 1'b0; // level driven
  // a released line settles to the enabled pull, else to the inverse level
  always_comb ctrl_pin_o = drv_en ? drv_val : (pullup_en_i ? 1'b1 :
    (pulldown_en_i ? 1'b0 : ~drv_val));
  task drive(input logic v);
    drv_en = 1'b1;
    drv_val = v;
  endtask
  task hold(input int cyc);
    repeat (cyc) @(posedge clk_i);
    #5;
  endtask
  task pulse(input int cyc);
    drive(1'b1);
    hold(cyc);
    drive(1'b0);
  endtask
endmodule // pss_ctrl_source
`default_nettype wire

//--- verif/pss_sequencer_bench.sv
/*
  self-checking bench of the power supervision sequencer.
  assumes a shortened tick and short user timings in position a.
*/
`timescale 1ns/100ps
`default_nettype none
module pss_sequencer_bench;
  import pss_pkg::*;
  localparam int T = 2; // cycles per tick
  localparam int DON = 3; // user on debounce, ticks
  localparam int DOFF = 4; // user off debounce, ticks
  localparam int DST = 10; // user start-up hold, ticks
  localparam int DHD = 20; // user hard-off, ticks
  logic clk;
  logic rst; // synchronous reset, held by restart
  logic [3:0] cfg_sw; // input configuration switch
  logic [3:0] sel_sw; // timing select switch
  logic supply_ok; // supply present
  logic booted; // processor boot done
  logic stop_bit, ready_bit, aux_bit; // register bits behind the leds
  logic ctrl_pin, flag_n, pulldown_en, pullup_en, shutdown_req, main_power_on;
  logic led_red, led_green, led_aux, p;
  logic [3:0] idle_sel [3] = '{4'h0, 4'hb, 4'hf}; // positions that must not act
  int num_errors = 0;
  int tests_run = 0;
  int n;
  // ==========================================================================
  // design and partner
  // ==========================================================================
  pss_sequencer #(.TICK_CYCLES_P(T), .USER_DEB_ON_P(DON), .USER_DEB_OFF_P(DOFF),
    .USER_START_P(DST), .USER_HARD_P(DHD)) i_pss_sequencer (
    .clk_i(clk), .reset_i(rst), .input_config_switch_i(cfg_sw),
    .timing_select_switch_i(sel_sw), .ctrl_pin_i(ctrl_pin), .supply_ok_i(supply_ok),
    .booted_i(booted), .stop_bit_i(stop_bit), .board_ready_bit_i(ready_bit),
    .aux_bit_i(aux_bit), .supply_loss_flag_n_o(flag_n), .pulldown_en_o(pulldown_en),
    .pullup_en_o(pullup_en), .shutdown_req_o(shutdown_req),
    .main_power_on_o(main_power_on), .led_red_o(led_red), .led_green_o(led_green),
    .led_aux_o(led_aux));
  pss_ctrl_source i_pss_ctrl_source (.clk_i(clk), .pullup_en_i(pullup_en),
    .pulldown_en_i(pulldown_en), .ctrl_pin_o(ctrl_pin));
  // ==========================================================================
  // helpers
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task step(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // waits a bounded time for the request (pwr 0) or the power output (pwr 1)
  task wait_out(input bit pwr, input logic v, input int lim, output int k);
    k = 0;
    while ((pwr ? main_power_on : shutdown_req) !== v && k < lim) begin
      step(1);
      k++;
    end
  endtask
  task restart(input logic [3:0] c, input logic [3:0] s, input int k);
    cfg_sw = c;
    sel_sw = s;
    i_pss_ctrl_source.drive(1'b0);
    rst = 1'b1;
    step(k);
    rst = 1'b0;
    step(2);
  endtask
  function automatic logic exp_flag(input logic [3:0] c, input logic v);
    return (c == CFG_TEST) ? 1'b0 : ((c == CFG_PULLUP) ? v : 1'b1);
  endfunction
  task report_and_stop;
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  // ==========================================================================
  initial begin
    void'($urandom(32'h230c));
    {supply_ok, booted} = 2'b11;
    {stop_bit, ready_bit, aux_bit} = 3'b000;
    restart(CFG_PULLUP, SEL_BYPASS, 12);
    // every configuration code with a random pin and random led bits
    for (int c = 0; c < 16; c++) begin
      p = 1'($urandom);
      cfg_sw = c[3:0];
      {stop_bit, ready_bit, aux_bit} = 3'($urandom);
      {supply_ok, booted} = 2'($urandom);
      i_pss_ctrl_source.drive(p);
      step(5);
      chk("pulldown", pulldown_en, c == 1);
      chk("pullup", pullup_en, c == 2);
      chk("flag", flag_n, exp_flag(c[3:0], p));
      chk("leds", {led_red, led_green, led_aux}, {stop_bit, ready_bit, aux_bit});
      chk("bypass outputs", {main_power_on, shutdown_req}, 2'b10);
    end
    {supply_ok, booted} = 2'b11;
    // bypass and reserved positions ignore an active pin
    foreach (idle_sel[i]) begin
      restart(CFG_PULLDOWN, idle_sel[i], 3);
      i_pss_ctrl_source.drive(1'b1);
      step(60);
      chk("idle power", main_power_on, 1'b1);
      chk("idle request", shutdown_req, 1'b0);
    end
    // user timings: glitch, debounce, hard-off, release
    restart(CFG_PULLDOWN, SEL_USER, 3);
    i_pss_ctrl_source.pulse(T);
    step(40);
    chk("glitch", shutdown_req, 1'b0);
    i_pss_ctrl_source.drive(1'b1);
    wait_out(0, 1'b1, 100, n);
    chk("debounce on", n >= DON * T && n <= DON * T + T + 6, 1'b1);
    wait_out(1, 1'b0, 200, n);
    chk("hard off", n >= (DHD - 1) * T && n <= DHD * T + T + 4, 1'b1);
    i_pss_ctrl_source.drive(1'b0);
    wait_out(1, 1'b1, 100, n);
    chk("release on", n >= (DOFF - 1) * T && n <= 2 * DOFF * T + 12, 1'b1);
    // table position four: one second on debounce
    restart(CFG_PULLDOWN, 4'h4, 3);
    i_pss_ctrl_source.drive(1'b1);
    wait_out(0, 1'b1, T_1S_MS * T + 40, n);
    chk("table debounce", n >= (T_1S_MS - 1) * T && n <= T_1S_MS * T + T + 6, 1'b1);
    // request while still booting is held
    booted = 1'b0;
    restart(CFG_PULLDOWN, SEL_USER, 3);
    i_pss_ctrl_source.drive(1'b1);
    wait_out(0, 1'b1, 200, n);
    chk("start-up hold", n >= (DON + DST - 1) * T && n <= (DON + DST + 2) * T + 6, 1'b1);
    booted = 1'b1;
    // pulse positions six to nine
    for (int m = 6; m < 10; m++) begin
      restart(CFG_PULLDOWN, m[3:0], 3);
      i_pss_ctrl_source.drive(1'b1);
      wait_out(m == 9, m != 9, 20, n);
      chk("pulse answer", n < 20, 1'b1);
      step(T_PULSE_MS * T - n);
      i_pss_ctrl_source.drive(1'b0);
      step(50);
      chk("after pulse", main_power_on, m != 9);
    end
    // long press in position eight, then start-up with and without supply
    restart(CFG_PULLDOWN, 4'h8, 3);
    i_pss_ctrl_source.drive(1'b1);
    wait_out(1, 1'b0, T_LONG_MS * T + 40, n);
    chk("long press", n >= (T_LONG_MS - 1) * T && n < T_LONG_MS * T + 40, 1'b1);
    supply_ok = 1'b0;
    i_pss_ctrl_source.drive(1'b0);
    step(40);
    i_pss_ctrl_source.pulse(T_PULSE_MS * T);
    step(40);
    chk("no supply", main_power_on, 1'b0);
    supply_ok = 1'b1;
    step(10);
    i_pss_ctrl_source.pulse(T_PULSE_MS * T);
    wait_out(1, 1'b1, 40, n);
    chk("pulse start", main_power_on, 1'b1);
    report_and_stop();
  end
  // watchdog well beyond the expected run
  initial begin
    #2000000;
    num_errors++;
    report_and_stop();
  end
endmodule // pss_sequencer_bench
`default_nettype wire

//--- verif/pss_sequencer_props.sv
/*
  port checker of the power supervision sequencer.
  assumes it is bound to pss_sequencer; one clock, sync reset high.
*/
`timescale 1ns/100ps
`default_nettype none
module pss_sequencer_props (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [3:0] input_config_switch_i,
  input wire logic [3:0] timing_select_switch_i,
  input wire logic ctrl_pin_i,
  input wire logic supply_ok_i,
  input wire logic booted_i,
  input wire logic stop_bit_i,
  input wire logic board_ready_bit_i,
  input wire logic aux_bit_i,
  input wire logic supply_loss_flag_n_o,
  input wire logic pulldown_en_o,
  input wire logic pullup_en_o,
  input wire logic shutdown_req_o,
  input wire logic main_power_on_o,
  input wire logic led_red_o,
  input wire logic led_green_o,
  input wire logic led_aux_o
);
  import pss_pkg::*;
  // ==========================================================================
  // properties
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  pull_enable_a: assert property (
    1 |=> pulldown_en_o == ($past(input_config_switch_i) == CFG_PULLDOWN)
      && pullup_en_o == ($past(input_config_switch_i) == CFG_PULLUP))
    else $error("pull enable does not match configuration");
  test_flag_a: assert property (
    input_config_switch_i == CFG_TEST |=> !supply_loss_flag_n_o)
    else $error("test configuration does not force the flag low");
  flag_follow_a: assert property (
    (input_config_switch_i == CFG_PULLUP && $stable(ctrl_pin_i))[*4]
      |-> supply_loss_flag_n_o == ctrl_pin_i)
    else $error("flag does not follow the pin");
  led_copy_a: assert property (
    1 |=> {led_red_o, led_green_o, led_aux_o}
      == $past({stop_bit_i, board_ready_bit_i, aux_bit_i}))
    else $error("led outputs do not follow their bits");
  bypass_idle_a: assert property (
    (input_config_switch_i == CFG_PULLDOWN && timing_select_switch_i == SEL_BYPASS)[*5]
      |-> main_power_on_o && !shutdown_req_o)
    else $error("bypass position acted on the pin");
  reserved_idle_a: assert property (
    (input_config_switch_i == CFG_PULLDOWN && timing_select_switch_i > SEL_USER)[*5]
      |-> main_power_on_o && !shutdown_req_o)
    else $error("reserved position acted on the pin");
  request_end_off_a: assert property (
    $fell(shutdown_req_o) && $past(timing_select_switch_i, 3) == timing_select_switch_i
      && $past(input_config_switch_i, 3) == input_config_switch_i
      && input_config_switch_i == CFG_PULLDOWN
      |-> !main_power_on_o)
    else $error("request ended without power off");
  no_restart_a: assert property (
    !main_power_on_o && input_config_switch_i == CFG_PULLDOWN && $stable(timing_select_switch_i)
      && (timing_select_switch_i == 4'h7 || timing_select_switch_i == 4'h9)
      |=> !main_power_on_o)
    else $error("power restarted in a mode without start-up");
  // main scenarios reached
  cover property ($rose(shutdown_req_o));
  cover property ($fell(main_power_on_o));
  cover property ($rose(main_power_on_o));
endmodule // pss_sequencer_props

bind pss_sequencer pss_sequencer_props i_pss_sequencer_props (
  .clk_i(clk_i), .reset_i(reset_i), .input_config_switch_i(input_config_switch_i),
  .timing_select_switch_i(timing_select_switch_i), .ctrl_pin_i(ctrl_pin_i),
  .supply_ok_i(supply_ok_i), .booted_i(booted_i), .stop_bit_i(stop_bit_i),
  .board_ready_bit_i(board_ready_bit_i), .aux_bit_i(aux_bit_i),
  .supply_loss_flag_n_o(supply_loss_flag_n_o), .pulldown_en_o(pulldown_en_o),
  .pullup_en_o(pullup_en_o), .shutdown_req_o(shutdown_req_o),
  .main_power_on_o(main_power_on_o), .led_red_o(led_red_o), .led_green_o(led_green_o),
  .led_aux_o(led_aux_o));
`default_nettype wire
